// ==== hdl/acp_pkg.sv ====
// Constants, link states and shared decoding for the serial command port
// Assumes one converter core behind the port and a host that clocks the link
//
// Functional notes
// R1: Eight-bit command register, written only, never read.
// R2: Host opens every transaction with a command byte.
// R3: Command byte picks next access direction and register.
// R4: After the selected access, wait for command again.
// R5: Reset leaves the port waiting for a command.
// R6: Thirty-two consecutive ones on data-in reset everything; the code keeps the data register value.
// R7: Command arrives MSB first; fields reset to zero.
// R8: Leading one holds position; zero starts seven-bit load.
// R9: Host always writes zero into bit six.
// R10: Direction zero writes, direction one reads.
// R11: Continuous read streams data register without commands.
// R12: Host enters continuous read with 001111XX.
// R13: Host exits with 001110XX while ready is low.
// R14: Data-in stays watched during continuous read.
// R15: Host holds data-in low during continuous read.
// R16: Channel field picks differential, shorted or supply input.
// R17: Channel change restarts filter and conversion.
// R18: Select: command/status, mode, reserved, data register.
// R19: Output bits change on falling, valid on rising.
// R20: Ready line low flags a fresh conversion result.
package acp_pkg;

   // Command byte layout
   localparam int          CMD_W          = 8;
   localparam int          CMD_ZERO_BIT   = 6;
   localparam int          CMD_SEL_HI     = 5;   // reg_select_hi
   localparam int          CMD_SEL_LO     = 4;   // reg_select_lo
   localparam int          CMD_DIR_BIT    = 3;
   localparam int          CMD_CONTINUOUS_READ_BIT_BIT  = 2;   // continuous_read_bit
   localparam int          CMD_CH_HI      = 1;   // channel_sel_hi
   localparam int          CMD_CH_LO      = 0;   // channel_sel_lo
   localparam logic [7:0]  CMD_RESET      = 8'h00;
   localparam logic [7:0]  MODE_RESET     = 8'h02;

   // Register select codes
   localparam logic [1:0]  SEL_COMM       = 2'h0;
   localparam logic [1:0]  SEL_MODE       = 2'h1;
   localparam logic [1:0]  SEL_RSVD       = 2'h2;
   localparam logic [1:0]  SEL_DATA       = 2'h3;

   // Channel codes
   localparam logic [1:0]  CH_DIFF        = 2'h0;
   localparam logic [1:0]  CH_SHORT       = 2'h2;
   localparam logic [1:0]  CH_SUPPLY      = 2'h3;

   // Exit pattern, top six bits of 001110XX
   localparam logic [5:0]  EXIT_CMD_TOP   = 6'h0e;

   // Serial counts
   localparam logic [5:0]  ONES_RESET_LAST = 6'h1f;  // 32nd one
   localparam logic [5:0]  CMD_TAIL_LAST   = 6'h06;  // Seventh bit after gate
   localparam logic [5:0]  BYTE_LAST       = 6'h07;
   localparam logic [2:0]  BYTE_PHASE_LAST = 3'h7;
   localparam logic [2:0]  STATUS_FIXED    = 3'h1;   // Status bits 5..3

   typedef enum logic [2:0] {
      ACP_IDLE  = 3'b000,
      ACP_CMD   = 3'b001,
      ACP_WRITE = 3'b010,
      ACP_READ  = 3'b011,
      ACP_CONT  = 3'b100
   } acp_link_state_t;

   function automatic logic [1:0] selOf(input logic [7:0] cmd);
      selOf = cmd[CMD_SEL_HI:CMD_SEL_LO];
   endfunction : selOf

   function automatic logic isContRead(input logic [7:0] cmd);
      isContRead = cmd[CMD_DIR_BIT] && cmd[CMD_CONTINUOUS_READ_BIT_BIT] && (selOf(cmd) == SEL_DATA);
   endfunction : isContRead

endpackage : acp_pkg

// ==== hdl/acp_sync.sv ====
// Two-stage synchroniser for a group of independent levels or toggles
// Assumes each bit is crossed on its own; no word coherence implied
`timescale 1ns/1ps
`default_nettype none
module acp_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock and reset
   input  wire logic             clk,
   input  wire logic             rstN,
   input  wire logic             en,
   // Levels from the other domain
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage1_next;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage2_next;

   // First stage feeds only the second
   always_comb begin
      stage1_next = en ? asyncIn : stage1_reg;
      stage2_next = en ? stage1_reg : stage2_reg;
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign syncOut = stage2_reg;
endmodule : acp_sync
`default_nettype wire

// ==== hdl/acp_serial_port.sv ====
// Serial command port: command byte, register access, continuous read
// Assumes sclk comes from the host and may stop between frames
`timescale 1ns/1ps
`default_nettype none
module acp_serial_port #(
   parameter int DATA_W = 24
) (
   // Core clock, reset and enable
   input  wire logic              core_clk,
   input  wire logic              rstn,
   input  wire logic              clkEn,
   // Serial link pins
   input  wire logic              sclk,
   input  wire logic              csN,
   input  wire logic              din,
   output logic                   doutOut,
   output logic                   doutOe,
   // Converter core side
   input  wire logic [DATA_W-1:0] convData,
   input  wire logic              convValid,
   input  wire logic              convErr,
   output logic      [1:0]        chanSel,
   output logic                   filterRestart,
   output logic      [7:0]        modeByte,
   output logic                   contReadOn
);
   localparam int PUB_W = DATA_W + 8;

   // Core reset release
   logic [1:0] coreRstPipe_reg;
   logic       coreRstN;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         coreRstPipe_reg <= 2'h0;
      end else begin
         coreRstPipe_reg <= {coreRstPipe_reg[0], 1'b1};
      end
   end
   assign coreRstN = coreRstPipe_reg[1];

   // Link reset release; needs two sclk edges after rstn rises
   logic [1:0] linkRstPipe_reg;
   logic       linkRstN;
   always_ff @(posedge sclk or negedge rstn) begin
      if (!rstn) begin
         linkRstPipe_reg <= 2'h0;
      end else begin
         linkRstPipe_reg <= {linkRstPipe_reg[0], 1'b1};
      end
   end
   assign linkRstN = linkRstPipe_reg[1];

   // Core state visible to the link
   logic             pubTog_reg;
   logic [PUB_W-1:0] pubWord_reg;

   // Link state
   acp_pkg::acp_link_state_t state_reg, state_next;
   logic [5:0]        bitCnt_reg,   bitCnt_next;
   logic [5:0]        bitLim_reg,   bitLim_next;
   logic [5:0]        onesCnt_reg,  onesCnt_next;
   logic [7:0]        shIn_reg,     shIn_next;
   logic [7:0]        cmd_reg,      cmd_next;
   logic [DATA_W-1:0] outSh_reg,    outSh_next;
   logic [7:0]        modeHold_reg, modeHold_next;
   logic [PUB_W-1:0]  pubLocal_reg, pubLocal_next;
   logic              cmdTog_reg,   cmdTog_next;
   logic              modeTog_reg,  modeTog_next;
   logic              readTog_reg,  readTog_next;
   logic              onesTog_reg,  onesTog_next;
   logic              ackTog_reg,   ackTog_next;
   logic              busy_reg,     busy_next;
   logic              sdo_reg;

   // Core-to-link crossings: enable, publish toggle, ready level
   logic [2:0] linkIn;
   logic       linkEn;
   logic       pubTogL;
   logic       readyNL;
   acp_sync #(.WIDTH(3)) u_linkSync (
      .clk     (sclk),
      .rstN    (linkRstN),
      .en      (1'b1),
      .asyncIn ({clkEn, pubTog_reg, pubWord_reg[PUB_W-1]}),
      .syncOut (linkIn)
   );
   assign linkEn  = linkIn[2];
   assign pubTogL = linkIn[1];
   assign readyNL = linkIn[0];

   // Link next state: command shift, access phase, ones watch
   always_comb begin
      logic [7:0] cmdNew;
      logic [7:0] byteIn;
      cmdNew        = {1'b0, shIn_reg[5:0], din};
      byteIn        = {shIn_reg[6:0], din};
      state_next    = state_reg;
      bitCnt_next   = bitCnt_reg;
      bitLim_next   = bitLim_reg;
      onesCnt_next  = onesCnt_reg;
      shIn_next     = shIn_reg;
      cmd_next      = cmd_reg;
      outSh_next    = outSh_reg;
      modeHold_next = modeHold_reg;
      pubLocal_next = pubLocal_reg;
      cmdTog_next   = cmdTog_reg;
      modeTog_next  = modeTog_reg;
      readTog_next  = readTog_reg;
      onesTog_next  = onesTog_reg;
      ackTog_next   = ackTog_reg;
      if (linkEn) begin
         // Take a new core snapshot; pubWord_reg is held until acked
         if (pubTogL != ackTog_reg) begin
            pubLocal_next = pubWord_reg;
            ackTog_next   = pubTogL;
         end
         if (!csN) begin
            onesCnt_next = din ? onesCnt_reg + 6'h01 : 6'h00;
            if (din && onesCnt_reg == acp_pkg::ONES_RESET_LAST) begin
               // Resynchronising reset of link state, command, mode, ready and error [R6]
               state_next   = acp_pkg::ACP_IDLE;
               bitCnt_next  = 6'h00;
               onesCnt_next = 6'h00;
               cmd_next     = acp_pkg::CMD_RESET;
               modeHold_next = acp_pkg::MODE_RESET;
               onesTog_next = ~onesTog_reg;
            end else begin
               case (state_reg)
                  acp_pkg::ACP_IDLE: begin
                     // A leading one holds the write gate position [R8]
                     if (!din) begin
                        state_next  = acp_pkg::ACP_CMD;
                        bitCnt_next = 6'h00;
                        shIn_next   = 8'h00;
                     end
                  end
                  acp_pkg::ACP_CMD: begin
                     // Seven bits MSB first after the gate [R7] [R8]
                     shIn_next   = byteIn;
                     bitCnt_next = bitCnt_reg + 6'h01;
                     if (bitCnt_reg == acp_pkg::CMD_TAIL_LAST) begin
                        cmd_next    = cmdNew;  // [R1]
                        cmdTog_next = ~cmdTog_reg;
                        bitCnt_next = 6'h00;
                        bitLim_next = acp_pkg::BYTE_LAST;
                        // Direction and select steer the next access [R3] [R10] [R18]
                        if (cmdNew[acp_pkg::CMD_DIR_BIT]) begin
                           case (acp_pkg::selOf(cmdNew))
                              acp_pkg::SEL_COMM: begin
                                 outSh_next = {pubLocal_reg[PUB_W-1 -: 8], {(DATA_W-8){1'b0}}};
                              end
                              acp_pkg::SEL_MODE: begin
                                 outSh_next = {modeHold_reg, {(DATA_W-8){1'b0}}};
                              end
                              acp_pkg::SEL_DATA: begin
                                 outSh_next  = pubLocal_reg[DATA_W-1:0];
                                 bitLim_next = 6'(DATA_W - 1);
                              end
                              default: begin
                                 outSh_next = '0;
                              end
                           endcase
                           state_next = acp_pkg::isContRead(cmdNew) ? acp_pkg::ACP_CONT
                                                                    : acp_pkg::ACP_READ;
                        end else if (acp_pkg::selOf(cmdNew) == acp_pkg::SEL_COMM) begin
                           state_next = acp_pkg::ACP_IDLE;  // Nothing follows [R4]
                        end else begin
                           state_next = acp_pkg::ACP_WRITE;
                        end
                     end
                  end
                  acp_pkg::ACP_WRITE: begin
                     shIn_next   = byteIn;
                     bitCnt_next = bitCnt_reg + 6'h01;
                     if (bitCnt_reg == acp_pkg::BYTE_LAST) begin
                        // Reserved register writes are dropped
                        if (acp_pkg::selOf(cmd_reg) == acp_pkg::SEL_MODE) begin
                           modeHold_next = byteIn;
                           modeTog_next  = ~modeTog_reg;
                        end
                        state_next = acp_pkg::ACP_IDLE;  // [R4]
                     end
                  end
                  acp_pkg::ACP_READ: begin
                     outSh_next  = {outSh_reg[DATA_W-2:0], 1'b0};
                     bitCnt_next = bitCnt_reg + 6'h01;
                     if (bitCnt_reg == bitLim_reg) begin
                        if (acp_pkg::selOf(cmd_reg) == acp_pkg::SEL_DATA) begin
                           readTog_next = ~readTog_reg;
                        end
                        state_next = acp_pkg::ACP_IDLE;  // [R4]
                     end
                  end
                  acp_pkg::ACP_CONT: begin
                     // Reload the data word after every full word of bitLim_reg + 1 bits [R11]
                     outSh_next  = {outSh_reg[DATA_W-2:0], 1'b0};
                     shIn_next   = byteIn;
                     bitCnt_next = bitCnt_reg + 6'h01;
                     if (bitCnt_reg == bitLim_reg) begin
                        bitCnt_next  = 6'h00;
                        outSh_next   = pubLocal_reg[DATA_W-1:0];
                        readTog_next = ~readTog_reg;
                     end
                     // Byte-aligned watch of data-in for the exit command [R14] [R13]
                     if (bitCnt_reg[2:0] == acp_pkg::BYTE_PHASE_LAST && !readyNL
                         && byteIn[7:2] == acp_pkg::EXIT_CMD_TOP) begin
                        cmd_next    = byteIn;
                        cmdTog_next = ~cmdTog_reg;
                        bitCnt_next = 6'h00;
                        state_next  = acp_pkg::ACP_IDLE;
                     end
                  end
                  default: begin
                     state_next = acp_pkg::ACP_IDLE;
                  end
               endcase
            end
         end else if (state_reg == acp_pkg::ACP_CONT && bitCnt_reg == 6'h00) begin
            // Refresh the streamed word between bursts; needs clocks with select high [R11]
            outSh_next = pubLocal_reg[DATA_W-1:0];
         end
      end
      busy_next = (state_next == acp_pkg::ACP_READ) || (state_next == acp_pkg::ACP_CONT);
   end

   // Link registers; reset leaves the port awaiting a command [R5]
   always_ff @(posedge sclk or negedge linkRstN) begin
      if (!linkRstN) begin
         state_reg    <= acp_pkg::ACP_IDLE;
         bitCnt_reg   <= 6'h00;
         bitLim_reg   <= acp_pkg::BYTE_LAST;
         onesCnt_reg  <= 6'h00;
         shIn_reg     <= 8'h00;
         cmd_reg      <= acp_pkg::CMD_RESET;
         outSh_reg    <= '0;
         modeHold_reg <= acp_pkg::MODE_RESET;
         pubLocal_reg <= '0;
         cmdTog_reg   <= 1'b0;
         modeTog_reg  <= 1'b0;
         readTog_reg  <= 1'b0;
         onesTog_reg  <= 1'b0;
         ackTog_reg   <= 1'b0;
         busy_reg     <= 1'b0;
      end else begin
         state_reg    <= state_next;
         bitCnt_reg   <= bitCnt_next;
         bitLim_reg   <= bitLim_next;
         onesCnt_reg  <= onesCnt_next;
         shIn_reg     <= shIn_next;
         cmd_reg      <= cmd_next;
         outSh_reg    <= outSh_next;
         modeHold_reg <= modeHold_next;
         pubLocal_reg <= pubLocal_next;
         cmdTog_reg   <= cmdTog_next;
         modeTog_reg  <= modeTog_next;
         readTog_reg  <= readTog_next;
         onesTog_reg  <= onesTog_next;
         ackTog_reg   <= ackTog_next;
         busy_reg     <= busy_next;
      end
   end

   // Output bit moves on the falling edge, stable for the rising one [R19]
   logic sdo_next;
   always_comb begin
      sdo_next = linkEn ? outSh_reg[DATA_W-1] : sdo_reg;
   end
   always_ff @(negedge sclk or negedge linkRstN) begin
      if (!linkRstN) begin
         sdo_reg <= 1'b1;
      end else begin
         sdo_reg <= sdo_next;
      end
   end

   // Link-to-core crossings; select crossed active high so reset reads as deselected
   logic [7:0] coreIn;
   acp_sync #(.WIDTH(8)) u_coreSync (
      .clk     (core_clk),
      .rstN    (coreRstN),
      .en      (clkEn),
      .asyncIn ({~csN, busy_reg, sdo_reg, cmdTog_reg, modeTog_reg, readTog_reg, onesTog_reg, ackTog_reg}),
      .syncOut (coreIn)
   );

   // Core state
   logic [7:0]        cmdByte_reg,   cmdByte_next;
   logic [7:0]        modeByte_reg,  modeByte_next;
   logic [DATA_W-1:0] data_reg,      data_next;
   logic              readyN_reg,    readyN_next;
   logic              err_reg,       err_next;
   logic [3:0]        evtPrev_reg,   evtPrev_next;
   logic              restart_reg,   restart_next;
   logic              pubTog_next;
   logic [PUB_W-1:0]  pubWord_next;
   logic              doutOut_reg,   doutOut_next;
   logic              doutOe_reg,    doutOe_next;
   logic              contRead_reg,  contRead_next;

   // Command copy as last written over the link; stable once its toggle is seen
   logic [7:0] pubLocalCmd;
   assign pubLocalCmd = cmd_reg;

   // Core next state: command copy, mode, data, ready, publication
   always_comb begin
      logic [3:0]       evt;
      logic [7:0]       status;
      logic [PUB_W-1:0] curWord;
      evt           = coreIn[4:1] ^ evtPrev_reg;
      cmdByte_next  = cmdByte_reg;
      modeByte_next = modeByte_reg;
      data_next     = data_reg;
      readyN_next   = readyN_reg;
      err_next      = err_reg;
      evtPrev_next  = evtPrev_reg;
      restart_next  = 1'b0;
      pubTog_next   = pubTog_reg;
      pubWord_next  = pubWord_reg;
      doutOut_next  = doutOut_reg;
      doutOe_next   = doutOe_reg;
      status        = {readyN_reg, err_reg, acp_pkg::STATUS_FIXED, 1'(DATA_W > 16),
                       cmdByte_reg[acp_pkg::CMD_CH_HI:acp_pkg::CMD_CH_LO]};
      curWord       = {status, data_reg};
      if (clkEn) begin
         evtPrev_next = coreIn[4:1];
         // Data register read done or mode write sets ready high
         if (evt[1] || evt[2]) begin
            readyN_next = 1'b1;
         end
         if (evt[3]) begin
            cmdByte_next = pubLocalCmd;
            // New channel restarts filter and conversion [R16] [R17]
            if (pubLocalCmd[acp_pkg::CMD_CH_HI:acp_pkg::CMD_CH_LO]
                != cmdByte_reg[acp_pkg::CMD_CH_HI:acp_pkg::CMD_CH_LO]) begin
               restart_next = 1'b1;
               readyN_next  = 1'b1;
            end
         end
         if (evt[2]) begin
            modeByte_next = modeHold_reg;
            restart_next  = 1'b1;
            err_next      = 1'b0;
         end
         if (evt[0]) begin
            cmdByte_next  = acp_pkg::CMD_RESET;  // [R6]
            modeByte_next = acp_pkg::MODE_RESET;
            readyN_next   = 1'b1;
            err_next      = 1'b0;
            restart_next  = 1'b1;
         end
         // A fresh result wins over any same-cycle clear [R20]
         if (convValid) begin
            data_next   = convData;
            err_next    = convErr;
            readyN_next = 1'b0;
         end
         // Publish only once the link has taken the last word
         if (pubTog_reg == coreIn[0] && curWord != pubWord_reg) begin
            pubWord_next = curWord;
            pubTog_next  = ~pubTog_reg;
         end
         // Pin: shifted bit during read access, else ready level [R19] [R20]
         doutOe_next  = coreIn[7];
         doutOut_next = coreIn[6] ? coreIn[5] : readyN_reg;
      end
      contRead_next = acp_pkg::isContRead(cmdByte_next);  // [R11]
   end

   always_ff @(posedge core_clk or negedge coreRstN) begin
      if (!coreRstN) begin
         cmdByte_reg  <= acp_pkg::CMD_RESET;
         modeByte_reg <= acp_pkg::MODE_RESET;
         data_reg     <= '0;
         readyN_reg   <= 1'b1;
         err_reg      <= 1'b0;
         evtPrev_reg  <= 4'h0;
         restart_reg  <= 1'b0;
         pubTog_reg   <= 1'b0;
         pubWord_reg  <= '0;
         doutOut_reg  <= 1'b1;
         doutOe_reg   <= 1'b0;
         contRead_reg <= 1'b0;
      end else begin
         cmdByte_reg  <= cmdByte_next;
         modeByte_reg <= modeByte_next;
         data_reg     <= data_next;
         readyN_reg   <= readyN_next;
         err_reg      <= err_next;
         evtPrev_reg  <= evtPrev_next;
         restart_reg  <= restart_next;
         pubTog_reg   <= pubTog_next;
         pubWord_reg  <= pubWord_next;
         doutOut_reg  <= doutOut_next;
         doutOe_reg   <= doutOe_next;
         contRead_reg <= contRead_next;
      end
   end

   // Outputs straight from core flops
   assign doutOut       = doutOut_reg;
   assign doutOe        = doutOe_reg;
   assign chanSel       = cmdByte_reg[acp_pkg::CMD_CH_HI:acp_pkg::CMD_CH_LO];
   assign filterRestart = restart_reg;
   assign modeByte      = modeByte_reg;
   assign contReadOn    = contRead_reg;
endmodule : acp_serial_port
`default_nettype wire

// ==== verification/acp_serial_port_sva.sv ====
// Checker on the top ports of the serial command port
// Assumes binding onto acp_serial_port; core clock domain only
`timescale 1ns/1ps
`default_nettype none
module acp_serial_port_sva (
   // Core clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // Watched ports
   input wire logic       csN,
   input wire logic       doutOe,
   input wire logic [1:0] chanSel,
   input wire logic       filterRestart,
   input wire logic [7:0] modeByte,
   input wire logic       contReadOn
);
   logic [3:0] quietReg;
   logic [3:0] quietNext;

   // Cycles since select went high; serial updates must land soon after
   always_comb begin
      quietNext = csN ? (quietReg == 4'hf ? quietReg : quietReg + 4'h1) : 4'h0;
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) quietReg <= 4'h0;
      else quietReg <= quietNext;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   chk_reset_values: assert property ($rose(rstn) |-> chanSel == 2'h0 && modeByte == 8'h02 && !contReadOn)
      else $error("reset values wrong");
   chk_oe_off: assert property (csN [*4] |-> !doutOe)
      else $error("pin driven while deselected");
   chk_oe_on: assert property (!csN [*5] |-> doutOe)
      else $error("pin not driven while selected");
   chk_restart_pulse: assert property (filterRestart |=> !filterRestart)
      else $error("restart longer than one cycle");
   chk_chan_restart: assert property ($changed(chanSel) |-> ##[0:2] filterRestart)
      else $error("channel change without restart");
   chk_mode_restart: assert property ($changed(modeByte) |-> ##[0:2] filterRestart)
      else $error("mode change without restart");
   chk_mode_serial: assert property ($changed(modeByte) |-> quietReg < 4'hc)
      else $error("mode changed without serial access");
   chk_chan_serial: assert property ($changed(chanSel) |-> quietReg < 4'hc)
      else $error("channel changed without serial access");
   chk_cont_serial: assert property ($changed(contReadOn) |-> quietReg < 4'hc)
      else $error("continuous mode changed without serial access");
endmodule : acp_serial_port_sva

bind acp_serial_port acp_serial_port_sva CHK (.core_clk(core_clk), .rstn(rstn), .csN(csN), .doutOe(doutOe),
   .chanSel(chanSel), .filterRestart(filterRestart), .modeByte(modeByte), .contReadOn(contReadOn));
`default_nettype wire

// ==== verification/acp_host_model.sv ====
// Host model: frames bursts on the serial link at a 32 ns clock
// Assumes the bench calls its tasks; clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module acp_host_model (
   // Link pins
   output logic      sclk,
   output logic      csN,
   output logic      din,
   input  wire logic doutOut,
   input  wire logic doutOe
);
   logic lastBit;
   logic pinLevel;

   // Undriven pin shows the inverse of its last bit, never a stale copy
   always @* if (doutOe) lastBit = doutOut;
   assign pinLevel = doutOe ? doutOut : ~lastBit;
   initial begin
      lastBit = 1'b0;
      sclk = 1'b1;
      csN = 1'b1;
      din = 1'b0;
   end

   // One framed burst, MSB first; din moves on falling, sampled on rising
   task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h0;
      csN = 1'b0;
      #16;
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b0;
         din = tx[i];
         #16;
         sclk = 1'b1;
         rx = {rx[30:0], pinLevel};
         #16;
      end
      din = 1'b0;
      csN = 1'b1;
      #16;
   endtask : frame

   // Clocks with select high, needed after reset and for crossings
   task automatic idle(input int n);
      repeat (n) begin
         sclk = 1'b0;
         #16;
         sclk = 1'b1;
         #16;
      end
   endtask : idle
endmodule : acp_host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the serial command port
// Assumes the host model drives the link; core inputs moved 1 ns after edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        convValid = 1'b0;
   logic        convErr = 1'b0;
   logic [23:0] convData = 24'h0;
   logic        sclk, csN, din, doutOut, doutOe, filterRestart, contReadOn;
   logic [1:0]  chanSel;
   logic [7:0]  modeByte;
   logic [7:0]  md;
   logic [31:0] rx;
   logic [1:0]  chans [3] = '{acp_pkg::CH_SHORT, acp_pkg::CH_SUPPLY, acp_pkg::CH_DIFF};
   int          miscompares = 0;
   int          cmp_count = 0;

   always #2 core_clk = ~core_clk;

   acp_serial_port DUT (.core_clk(core_clk), .rstn(rstn), .clkEn(1'b1), .sclk(sclk), .csN(csN), .din(din),
      .doutOut(doutOut), .doutOe(doutOe), .convData(convData), .convValid(convValid), .convErr(convErr),
      .chanSel(chanSel), .filterRestart(filterRestart), .modeByte(modeByte), .contReadOn(contReadOn));
   acp_host_model HOST (.sclk(sclk), .csN(csN), .din(din), .doutOut(doutOut), .doutOe(doutOe));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim();
      $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   // Status byte: ready, error, fixed 001, width flag set for 24 bits, channel
   function automatic logic [7:0] statusOf(input logic rdyN, input logic err, input logic [1:0] ch);
      statusOf = {rdyN, err, 3'b001, 1'b1, ch};
   endfunction : statusOf

   // Let serial results cross into the core
   task automatic settle();
      repeat (12) @(posedge core_clk);
      #1;
   endtask : settle

   // One result pulse, then clocks so the link sees the snapshot
   task automatic convert(input logic err);
      @(posedge core_clk);
      #1;
      convData = 24'($urandom);
      convErr = err;
      convValid = 1'b1;
      @(posedge core_clk);
      #1;
      convValid = 1'b0;
      HOST.idle(8);  // Room for a pending snapshot plus the new one
   endtask : convert

   initial begin
      md = 8'($urandom(32'h960d));
      repeat (5) @(posedge core_clk);
      #1 rstn = 1'b1;
      HOST.idle(4);  // Two edges release link reset, two more the enable sync
      settle();
      check(chanSel, 2'h0);
      check(modeByte, 8'h02);
      check(contReadOn, 1'b0);
      HOST.frame(32'h0800, 16, rx);
      check(rx[7:0], statusOf(1'b1, 1'b0, 2'h0));
      HOST.frame({4'hf, 8'h10, md}, 20, rx);  // Leading ones then mode write
      settle();
      check(modeByte, md);
      HOST.frame({8'h18, 8'h00}, 16, rx);
      check(rx[7:0], md);
      HOST.frame({8'h20, ~md}, 16, rx);
      settle();
      check(modeByte, md);
      HOST.frame({8'h28, 8'h00}, 16, rx);
      check(rx[7:0], 8'h00);
      foreach (chans[i]) begin
         HOST.frame({6'h00, chans[i]}, 8, rx);
         settle();
         check(chanSel, chans[i]);
      end
      convert(1'b1);
      HOST.frame(32'h0800, 16, rx);
      check(rx[7:0], statusOf(1'b0, 1'b1, 2'h0));
      HOST.frame({8'h38, 24'h0}, 32, rx);
      check(rx[23:0], convData);
      HOST.frame(32'h0800, 16, rx);
      check(rx[7], 1'b1);
      HOST.frame(32'h3c, 8, rx);
      settle();
      check(contReadOn, 1'b1);
      convert(1'b0);
      HOST.frame(32'h0, 24, rx);
      check(rx[23:0], convData);
      convert(1'b0);
      HOST.frame(32'h38, 8, rx);
      check(rx[7:0], convData[23:16]);
      settle();
      check(contReadOn, 1'b0);
      HOST.frame({8'h13, ~md}, 16, rx);
      HOST.frame(32'hffffffff, 32, rx);
      settle();
      check(modeByte, 8'h02);
      check(chanSel, 2'h0);
      HOST.frame(32'h0800, 16, rx);
      check(rx[7:0], statusOf(1'b1, 1'b0, 2'h0));
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
